// ===== hdl/dacr_readout.sv
// Conversion control and parallel readout of a dual sampling converter.
// Assumes pins synchronous to clock and a host that keeps its side.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dacr_map.svh"
// Function
// - Drive bus only with chip select, read low
// - Data lines released when not reading
// - Software mode: shared pin is write strobe
// - Hardware mode: burst latched at reset release
// - Select inputs choose pair, hardware mode only
// - Rising start edge begins conversion
// - Busy rises after start edge
// - Busy falls as results load
// - Start edges ignored while busy
// - No burst or oversampling: one conversion
// - Burst/oversampling: one edge, whole series
// - Range inputs latch mode at reset
module dacr_readout
	import dacr_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic sys_rst, // Sync full reset
	input wire logic conversionStart, // Start input
	input wire dacr_pair_t channelPairSelect, // Pair select
	input wire logic [1:0] rangeModeSelect, // Range/mode select
	input wire logic interfaceSelect_n, // Must be low
	input wire logic chipSelect_n, // Chip select
	input wire logic read_n, // Read strobe
	input wire logic writeBurst_n, // Write or burst pin
	input wire dacr_word_t dataIn, // Bus input
	output dacr_word_t dataOut, // Bus output
	output logic dataOe_n, // Bus enable, low drives
	output logic busy, // Conversion busy
	input wire dacr_word_t sampleA, // Sampled value A
	input wire dacr_word_t sampleB, // Sampled value B
	input wire logic [7:0] regAddr, // Register address
	input wire logic [31:0] regWdata, // Register write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [31:0] regRdata, // Read data
	output logic irq // Interrupt level
);
	dacr_state_e state_reg;
	logic swMode_reg, burstPin_reg, rstSeen_reg, startPrev_reg;
	logic wrPrev_reg, resSel_reg;
	logic [7:0] swCtrl_reg;
	logic [1:0] irq_reg, mask_reg;
	logic [3:0] left_reg;
	dacr_pair_t pair_reg;
	dacr_word_t resA_reg, resB_reg;
	logic convDone;
	dacr_word_t codeA, codeB;

	function automatic logic [3:0] seriesLen(input logic burst,
		input logic osr);
		seriesLen = 4'h1;
		if (burst)
			seriesLen = 4'(`DACR_BURST_LEN);
		else if (osr)
			seriesLen = 4'(`DACR_OSR_LEN);
	endfunction

	////////////////////////////////////////////////////////////////
	// Edge detection and mode decoding
	// rising edge
	wire startEdge = conversionStart && !startPrev_reg;
	wire startTake = startEdge && state_reg == DACR_IDLE;
	wire startLost = startEdge && state_reg != DACR_IDLE;
	wire burstOn = swMode_reg ? swCtrl_reg[`DACR_CTRL_BURST] : burstPin_reg;
	wire osrOn = swCtrl_reg[`DACR_CTRL_OSR];
	// write strobe falling edge in software mode
	wire pinWrite = swMode_reg && !writeBurst_n && wrPrev_reg
		&& !chipSelect_n;
	wire lastConv = convDone && left_reg == 4'h1;
	// Results load on the very edge that drops busy
	wire loadNow = state_reg == DACR_LOAD;
	wire convStart = startTake || (convDone && left_reg != 4'h1);
	wire dacr_pair_t pickPair = swMode_reg ? pair_reg : channelPairSelect;
	wire dacr_pair_t nextPair = burstOn ? dacr_pair_t'(pair_reg + 3'h1)
		: pair_reg;

	dacr_pair_conv conv
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.start(convStart),
		.pair(startTake ? pickPair : nextPair),
		.sampleA(sampleA),
		.sampleB(sampleB),
		.done(convDone),
		.codeA(codeA),
		.codeB(codeB)
	);

	////////////////////////////////////////////////////////////////
	// Mode latching at full reset release
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rstSeen_reg <= 1'b0;
		else
			rstSeen_reg <= 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			swMode_reg <= 1'b1;
			burstPin_reg <= 1'b0;
		end
		else if (!rstSeen_reg)
		begin
			swMode_reg <= rangeModeSelect == 2'b00;
			burstPin_reg <= !writeBurst_n;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_reg <= DACR_IDLE;
			left_reg <= 4'h0;
			pair_reg <= 3'h0;
			startPrev_reg <= 1'b0;
			wrPrev_reg <= 1'b1;
		end
		else
		begin
			startPrev_reg <= conversionStart;
			wrPrev_reg <= writeBurst_n;
			case (state_reg)
				DACR_IDLE:
					if (startTake)
					begin
						left_reg <= seriesLen(burstOn, osrOn);
						pair_reg <= pickPair;
						state_reg <= DACR_CONV;
					end
				DACR_CONV:
					if (lastConv)
						state_reg <= DACR_LOAD;
					else if (convDone)
					begin
						left_reg <= left_reg - 4'h1;
						pair_reg <= nextPair;
					end
				default:
					state_reg <= DACR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			resA_reg <= 16'h0000;
			resB_reg <= 16'h0000;
		end
		else if (loadNow)
		begin
			resA_reg <= codeA;
			resB_reg <= codeB;
		end
	end

	assign busy = state_reg != DACR_IDLE;

	////////////////////////////////////////////////////////////////
	// Parallel bus: A then B on successive reads
	always_ff @(posedge clock)
	begin
		if (sys_rst || loadNow)
			resSel_reg <= 1'b0;
		else if (!read_n && !chipSelect_n && !busy)
			resSel_reg <= 1'b1;
	end

	assign dataOe_n = chipSelect_n || read_n || interfaceSelect_n;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			dataOut <= 16'h0000;
		else
			dataOut <= resSel_reg ? resB_reg : resA_reg;
	end

	////////////////////////////////////////////////////////////////
	// Register port and interrupts
	wire selCtrl = regAddr == `DACR_OFF_CTRL;
	wire selIrq = regAddr == `DACR_OFF_IRQ;
	wire selMask = regAddr == `DACR_OFF_MASK;
	wire [1:0] irqSet = {startLost, lastConv};
	wire [1:0] irqClr = (regWr && selIrq) ? regWdata[1:0] : 2'b00;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			swCtrl_reg <= `DACR_CTRL_RST;
			mask_reg <= 2'b00;
			irq_reg <= 2'b00;
		end
		else
		begin
			if (regWr && selMask)
				mask_reg <= regWdata[1:0];
			// Set wins over clear
			irq_reg <= (irq_reg & ~irqClr) | irqSet;
			// pin write strobe loads the mode register
			if (pinWrite)
				swCtrl_reg <= dataIn[7:0];
			else if (regWr && selCtrl && swMode_reg)
				swCtrl_reg <= regWdata[7:0];
		end
	end

	assign irq = |(irq_reg & mask_reg);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			regRdata <= 32'h0;
		else if (!regRd)
			regRdata <= 32'h0;
		else if (selCtrl)
			regRdata <= {24'h0, swCtrl_reg};
		else if (regAddr == `DACR_OFF_STAT)
			regRdata <= {27'h0, swMode_reg, burstPin_reg, left_reg == 4'h0,
				resSel_reg, busy};
		else if (selIrq)
			regRdata <= {30'h0, irq_reg};
		else if (selMask)
			regRdata <= {30'h0, mask_reg};
		else if (regAddr == `DACR_OFF_RESA)
			regRdata <= {16'h0, resA_reg};
		else if (regAddr == `DACR_OFF_RESB)
			regRdata <= {16'h0, resB_reg};
		else
			regRdata <= 32'h0;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	sequence startSeen;
		startTake;
	endsequence
	sequence busyHigh;
		busy;
	endsequence

	busy_rise_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		startSeen |=> busyHigh)
	else $error("busy did not rise after start");

	bus_drive_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(!chipSelect_n && !read_n && !interfaceSelect_n) |-> !dataOe_n)
	else $error("bus not driven on read");

	bus_release_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(chipSelect_n || read_n) |-> dataOe_n)
	else $error("bus driven while idle");

	bus_iface_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		interfaceSelect_n |-> dataOe_n)
	else $error("bus driven with interface deselected");

	busy_ignore_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(busy && startEdge) |=> $stable(pair_reg) || $past(convDone))
	else $error("start accepted while busy");

	load_fall_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		loadNow |=> !busy && resA_reg == $past(codeA))
	else $error("busy fell without load");

	single_conv_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(startTake && !burstOn && !osrOn) |=> left_reg == 4'h1)
	else $error("extra conversions queued");

	burst_series_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(startTake && burstOn) |=> left_reg == 4'(`DACR_BURST_LEN))
	else $error("burst series wrong length");

	pair_pick_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		(startTake && !swMode_reg) |=> pair_reg == $past(channelPairSelect))
	else $error("hardware pair not taken");

	mode_hold_a:
	assert property (@(posedge clock) disable iff (sys_rst)
		rstSeen_reg |=> $stable(swMode_reg) && $stable(burstPin_reg))
	else $error("mode changed after latch");
endmodule
`default_nettype wire

// ===== shared/dacr_map.svh
// Offsets, field positions, reset values and timing counts of the readout block.
// Assumes a 50 MHz system clock.
`ifndef DACR_MAP_SVH
`define DACR_MAP_SVH

`define DACR_CLK_MHZ 50
// Conversion time of one channel pair, ns
`define DACR_CONV_NS 500
`define DACR_CONV_CYC ((`DACR_CONV_NS * `DACR_CLK_MHZ + 999) / 1000)
`define DACR_BURST_LEN 8
`define DACR_OSR_LEN 2

// Plain register port offsets
`define DACR_OFF_CTRL 8'h00
`define DACR_OFF_STAT 8'h04
`define DACR_OFF_IRQ 8'h08
`define DACR_OFF_MASK 8'h0c
`define DACR_OFF_RESA 8'h10
`define DACR_OFF_RESB 8'h14

// Control fields
`define DACR_CTRL_OSR 0
`define DACR_CTRL_BURST 1
`define DACR_CTRL_RST 8'h00

// Interrupt fields
`define DACR_IRQ_DONE 0
`define DACR_IRQ_LOST 1

`endif

// ===== shared/dacr_pkg.sv
// Types of the readout block.
// Used with dacr_map.svh constants.
package dacr_pkg;
	typedef enum {DACR_IDLE, DACR_CONV, DACR_LOAD} dacr_state_e;
	typedef logic [15:0] dacr_word_t;
	typedef logic [2:0] dacr_pair_t;
endpackage

// ===== hdl/dacr_pair_conv.sv
// One converter pair model: counts a conversion time per pair.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`default_nettype none
`include "dacr_map.svh"
module dacr_pair_conv
	import dacr_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic sys_rst, // Sync reset
	input wire logic start, // Start one pair
	input wire dacr_pair_t pair, // Pair to convert
	input wire dacr_word_t sampleA, // Sample on A
	input wire dacr_word_t sampleB, // Sample on B
	output logic done, // One-cycle done
	output dacr_word_t codeA, // Result A
	output dacr_word_t codeB // Result B
);
	logic [7:0] cnt_reg;
	logic run_reg;
	// Pair held from start, the select input may move on meanwhile
	dacr_pair_t pair_reg;
	wire lastCyc = run_reg && (cnt_reg == 8'(`DACR_CONV_CYC - 1));

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cnt_reg <= 8'h00;
			run_reg <= 1'b0;
			pair_reg <= 3'h0;
			done <= 1'b0;
			codeA <= 16'h0000;
			codeB <= 16'h0000;
		end
		else
		begin
			done <= lastCyc;
			if (start)
			begin
				run_reg <= 1'b1;
				cnt_reg <= 8'h00;
				pair_reg <= pair;
			end
			else if (lastCyc)
			begin
				run_reg <= 1'b0;
				// Pair index folded in so pair choice is observable
				codeA <= sampleA ^ {13'h0000, pair_reg};
				codeB <= sampleB ^ {13'h0000, pair_reg};
			end
			else if (run_reg)
				cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== test/dacr_host_model.sv
// Host side model: start pulses, parallel reads, write strobes.
// Assumes the block and this model share one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dacr_host_model
	import dacr_pkg::*;
(
	input wire logic clock, // System clock
	input wire dacr_word_t dataOut, // Block bus drive
	input wire logic dataOe_n, // Block bus enable
	output logic conversionStart, // Start input
	output dacr_pair_t channelPairSelect, // Pair select
	output logic chipSelect_n, // Chip select
	output logic read_n, // Read strobe
	output logic writeBurst_n, // Write or burst
	output logic interfaceSelect_n, // Parallel select
	output dacr_word_t dataIn // Resolved bus
);
	dacr_word_t hostData;
	dacr_word_t lastBus;
	logic hostDrive;
	// Released bus keeps changing, never a stale value
	assign dataIn = hostDrive ? hostData :
		(dataOe_n === 1'b0 ? dataOut : ~lastBus);
	always @(posedge clock)
		lastBus <= dataIn;
	initial
	begin
		interfaceSelect_n = 1'b0;
		conversionStart = 1'b0;
		channelPairSelect = 3'h0;
		chipSelect_n = 1'b1;
		read_n = 1'b1;
		writeBurst_n = 1'b1;
		hostDrive = 1'b0;
		hostData = 16'h0000;
		lastBus = 16'h0000;
	end
	////////////////////////////////////////
	task setBurst(input logic b);
		writeBurst_n <= b;
	endtask
	// Deliberate misuse, to see the bus stay released
	task setIface(input logic v);
		@(posedge clock) interfaceSelect_n <= v;
	endtask
	// select settles a cycle before start
	task convert(input dacr_pair_t p);
		@(posedge clock) channelPairSelect <= p;
		@(posedge clock) conversionStart <= 1'b1;
		@(posedge clock) conversionStart <= 1'b0;
		#1;
	endtask
	task busRead(output dacr_word_t a, output dacr_word_t b,
		output logic oe);
		@(posedge clock)
		begin
			chipSelect_n <= 1'b0;
			read_n <= 1'b0;
		end
		#1 a = dataIn;
		oe = dataOe_n;
		repeat (2) @(posedge clock);
		#1 b = dataIn;
		@(posedge clock)
		begin
			chipSelect_n <= 1'b1;
			read_n <= 1'b1;
		end
		#1;
	endtask
	// shared pin as low write strobe
	task regWrite(input dacr_word_t d);
		@(posedge clock)
		begin
			hostDrive <= 1'b1;
			hostData <= d;
			chipSelect_n <= 1'b0;
			writeBurst_n <= 1'b0;
		end
		repeat (2) @(posedge clock);
		writeBurst_n <= 1'b1;
		@(posedge clock)
		begin
			hostDrive <= 1'b0;
			chipSelect_n <= 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the readout block and its host model.
// Assumes the block's map constants and one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "dacr_map.svh"
module tb_top
	import dacr_pkg::*;
;
	localparam int CYC = `DACR_CONV_CYC;
	localparam int BL = `DACR_BURST_LEN;
	localparam int OS = `DACR_OSR_LEN;
	logic clock;
	logic sys_rst;
	logic [1:0] rangeModeSelect;
	dacr_word_t sampleA;
	dacr_word_t sampleB;
	logic [7:0] regAddr;
	logic [31:0] regWdata;
	logic regWr;
	logic regRd;
	wire conversionStart;
	wire dacr_pair_t channelPairSelect;
	wire chipSelect_n;
	wire read_n;
	wire writeBurst_n;
	wire interfaceSelect_n;
	wire dacr_word_t dataIn;
	dacr_word_t dataOut;
	logic dataOe_n;
	logic busy;
	logic [31:0] regRdata;
	logic irq;
	logic [31:0] expQ[$];
	logic rdPend;
	int error_cnt;
	int cmp_count;
	int n;
	dacr_word_t ra;
	dacr_word_t rb;
	dacr_pair_t p;
	logic [31:0] rv;
	logic oe;
	dacr_readout DUT (.clock, .sys_rst, .conversionStart, .channelPairSelect,
		.rangeModeSelect, .interfaceSelect_n, .chipSelect_n, .read_n,
		.writeBurst_n, .dataIn, .dataOut, .dataOe_n, .busy, .sampleA,
		.sampleB, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);
	dacr_host_model host (.clock, .dataOut, .dataOe_n, .conversionStart,
		.channelPairSelect, .chipSelect_n, .read_n, .writeBurst_n,
		.interfaceSelect_n, .dataIn);
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish();
		$display("compares %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task regW(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock)
		begin
			regWr <= 1'b1;
			regAddr <= a;
			regWdata <= d;
		end
		@(posedge clock) regWr <= 1'b0;
	endtask
	task regR(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock)
		begin
			regRd <= 1'b1;
			regAddr <= a;
			expQ.push_back(e);
		end
		@(posedge clock) regRd <= 1'b0;
	endtask
	task doReset(input logic [1:0] r, input logic b);
		@(posedge clock)
		begin
			sys_rst <= 1'b1;
			rangeModeSelect <= r;
			host.setBurst(b);
		end
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	// host waits for busy low before reading
	task waitIdle(output int c);
		c = 1;
		while (busy !== 1'b0 && c < 400)
		begin
			@(posedge clock);
			#1 c++;
		end
		if (c >= 400)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clock)
	begin
		rdPend <= regRd;
		if (rdPend === 1'b1)
			check(regRdata, expQ.pop_front());
	end
	////////////////////////////////////////
	initial
	begin
		sys_rst = 1'b1;
		rangeModeSelect = 2'b01;
		sampleA = 16'h0000;
		sampleB = 16'h0000;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		rdPend = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		void'($urandom(32'h3c2d));
		doReset(2'b01, 1'b1);
		// pairs 0 and 1, then a random pair
		for (int i = 0; i < 3; i++)
		begin
			p = (i < 2) ? dacr_pair_t'(i) : dacr_pair_t'($urandom);
			sampleA <= dacr_word_t'($urandom);
			sampleB <= dacr_word_t'($urandom);
			host.convert(p);
			check(busy, 1'b1);
			waitIdle(n);
			check(n >= CYC && n <= CYC + 6, 1'b1);
			host.busRead(ra, rb, oe);
			check(oe, 1'b0);
			check(ra, sampleA ^ {13'h0, p});
			check(rb, sampleB ^ {13'h0, p});
			check(dataOe_n, 1'b1);
		end
		// invalid interface select keeps the bus released
		host.setIface(1'b1);
		host.busRead(ra, rb, oe);
		check(oe, 1'b1);
		host.setIface(1'b0);
		// second edge during busy is dropped
		regW(`DACR_OFF_IRQ, 32'h3);
		host.convert(3'h2);
		host.convert(3'h2);
		waitIdle(n);
		check(n <= CYC + 3, 1'b1);
		regR(`DACR_OFF_IRQ, 32'h3);
		check(irq, 1'b0);
		rv = $urandom;
		regW(`DACR_OFF_MASK, rv);
		regR(`DACR_OFF_MASK, {30'h0, rv[1:0]});
		regW(`DACR_OFF_MASK, 32'h2);
		repeat (2) @(posedge clock);
		#1 check(irq, 1'b1);
		regW(`DACR_OFF_IRQ, 32'h3);
		repeat (2) @(posedge clock);
		#1 check(irq, 1'b0);
		regR(`DACR_OFF_IRQ, 32'h0);
		regR(8'h20, 32'h0);
		// burst latched; later pin change has no effect
		doReset(2'b01, 1'b0);
		host.setBurst(1'b1);
		host.convert(3'h0);
		waitIdle(n);
		check(n >= BL * CYC && n <= BL * (CYC + 2) + 4, 1'b1);
		// software mode write turns on oversampling
		doReset(2'b00, 1'b1);
		host.regWrite(16'h0001);
		regR(`DACR_OFF_CTRL, 32'h1);
		host.convert(3'h0);
		waitIdle(n);
		check(n >= OS * CYC && n <= OS * (CYC + 2) + 4, 1'b1);
		// Software mode burst through the same pin write
		host.regWrite(16'h0002);
		host.convert(3'h0);
		waitIdle(n);
		check(n >= BL * CYC && n <= BL * (CYC + 2) + 4, 1'b1);
		repeat (3) @(posedge clock);
		tally_and_finish();
	end
endmodule
`default_nettype wire
